// ---- shared/hwm_irq_regs.svh ----
// register map, field positions, reset values and timing for the monitor control block
// assumes a 10 MHz system clock and an 8-bit port pair addressed by one select line
`ifndef HWM_IRQ_REGS_SVH
`define HWM_IRQ_REGS_SVH

// ****************************************
// register indices
// ****************************************
`define HWM_IDX_CFG 7'h40
`define HWM_IDX_STAT1 7'h41
`define HWM_IDX_STAT2 7'h42
`define HWM_IDX_SMIMASK1 7'h43
`define HWM_IDX_SMIMASK2 7'h44
`define HWM_IDX_HOSTMASK1 7'h45

// ****************************************
// reset values
// ****************************************
`define HWM_RST_CFG 8'h08
`define HWM_RST_ZERO 8'h00
`define HWM_RST_IDX 7'h00

// ****************************************
// configuration fields
// ****************************************
`define HWM_CFG_START 0
`define HWM_CFG_SMIEN 1
`define HWM_CFG_HOSTEN 2
`define HWM_CFG_GDIS 3
`define HWM_CFG_RSTPULSE 4
`define HWM_CFG_NMISEL 5
`define HWM_CFG_BYPASS 6
`define HWM_CFG_INIT 7

// ****************************************
// other fields
// ****************************************
`define HWM_MASK2_RSTPERM 7
`define HWM_ADDR_BUSY 7
`define HWM_STAT1_BOARDTEMP 5
`define HWM_STAT2_CASEOPEN 4
`define HWM_STAT2_POSTFULL 5
`define HWM_STAT2_CHAINED 6
`define HWM_STAT2_USED 8'h7f

// ****************************************
// timing
// ****************************************
`define HWM_CLK_HZ 10000000
`define HWM_RST_PULSE_MS 20
`define HWM_RST_PULSE_CYC ((`HWM_RST_PULSE_MS * `HWM_CLK_HZ + 999) / 1000)

`endif

// ---- shared/hwm_pkg.sv ----
// types shared by the monitor control block and its pulse timer
// assumes the register header for field widths
package hwm_pkg;

  // ****************************************
  // pulse timer
  // ****************************************
  typedef enum logic {HWM_TMR_IDLE, HWM_TMR_PULSE} hwm_tmr_state_t;

  typedef struct packed {
    hwm_tmr_state_t mode;
    logic [31:0] count;
    logic pulse_n;
    logic done;
  } hwm_tmr_t;

  // ****************************************
  // control block state
  // ****************************************
  typedef struct packed {
    logic [6:0] index;
    logic busy;
    logic [7:0] cfg;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] smiMask1;
    logic [7:0] smiMask2;
    logic [7:0] hostMask1;
    logic [7:0] rdData;
    logic smiOut_n;
    logic nmiOut_n;
    logic irqOut_n;
    logic bypass_n;
    logic monitorRun;
    logic caseOpenPrev;
    logic chainedPrev;
    logic pulseGo;
    logic pulseStop;
  } hwm_state_t;

endpackage

// ---- src/hwm_pulse_timer.sv ----
// fixed-length active-low pulse generator
// assumes a one-cycle start and a one-cycle abort from the control block
`timescale 1ns/100ps
`include "hwm_irq_regs.svh"
module hwm_pulse_timer
  import hwm_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `HWM_RST_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic pulse_n,
  output logic done
);

  if (PULSE_CYC < 1) begin : g_chk
    $error("pulse length must be at least one cycle");
  end

  localparam hwm_tmr_t TMR_RST = '{HWM_TMR_IDLE, 32'h0, 1'b1, 1'b0};

  hwm_tmr_t st;
  hwm_tmr_t next_st;

  // ****************************************
  // count down while the pulse is low
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.mode)
      HWM_TMR_IDLE: begin
        if (start && !abort) begin
          next_st.mode = HWM_TMR_PULSE;
          next_st.count = 32'(PULSE_CYC - 1);
          next_st.pulse_n = 1'b0;
        end
      end
      HWM_TMR_PULSE: begin
        if (abort || st.count == 32'h0) begin
          next_st.mode = HWM_TMR_IDLE;
          next_st.pulse_n = 1'b1;
          next_st.done = 1'b1;
        end else begin
          next_st.count = st.count - 32'h1;
        end
      end
      default: begin
        next_st = TMR_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= TMR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_n = st.pulse_n;
  assign done = st.done;

endmodule // hwm_pulse_timer

// ---- src/hwm_irq_ctrl.sv ----
// control, status and mask registers of the hardware monitor, behind an index/data port pair
// assumes host strobes and event inputs synchronous to clk_sys; alarm inputs are one-cycle pulses
`timescale 1ns/100ps
`include "hwm_irq_regs.svh"
module hwm_irq_ctrl
  import hwm_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `HWM_RST_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic portSel,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic [7:0] limitAlarm,
  input wire logic [2:0] tachAlarm,
  input wire logic boardTempAlert_n,
  input wire logic caseOpenIn,
  input wire logic postBufferFull,
  input wire logic chainedIrqIn_n,
  output logic systemMgmtIrqOut_n,
  output logic nmiOut_n,
  output logic irqOut_n,
  output logic resetOut_n,
  output logic powerBypassOut_n,
  output logic monitorEnable
);

  if (PULSE_CYC < 1) begin : g_chk
    $error("reset pulse length must be at least one cycle");
  end

  localparam hwm_state_t ST_RST = '{
    index: `HWM_RST_IDX,
    busy: 1'b0,
    cfg: `HWM_RST_CFG,
    stat1: `HWM_RST_ZERO,
    stat2: `HWM_RST_ZERO,
    smiMask1: `HWM_RST_ZERO,
    smiMask2: `HWM_RST_ZERO,
    hostMask1: `HWM_RST_ZERO,
    rdData: `HWM_RST_ZERO,
    smiOut_n: 1'b1,
    nmiOut_n: 1'b1,
    irqOut_n: 1'b1,
    bypass_n: 1'b1,
    monitorRun: 1'b0,
    caseOpenPrev: 1'b0,
    chainedPrev: 1'b1,
    pulseGo: 1'b0,
    pulseStop: 1'b0
  };

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic maskedAny(input logic [7:0] stat, input logic [7:0] mask);
    maskedAny = |(stat & ~mask);
  endfunction

  function automatic logic autoAdvance(input logic [6:0] idx);
    autoAdvance = (idx == `HWM_IDX_STAT1) || (idx == `HWM_IDX_SMIMASK1) ||
                  (idx == `HWM_IDX_HOSTMASK1);
  endfunction

  hwm_state_t st;
  hwm_state_t next_st;
  logic pulseDone;
  logic pulseLow_n;
  logic dataWr;
  logic dataRd;
  logic dataAcc;
  logic rdStat1;
  logic rdStat2;
  logic wrCfg;
  logic softInit;
  logic gdis;
  logic running;
  logic [7:0] set1;
  logic [7:0] set2;
  logic smiAny;
  logic hostAny;

  // ****************************************
  // port decode and event capture
  // ****************************************
  always_comb begin
    dataWr = wrStrobe && portSel;
    dataRd = rdStrobe && portSel && !wrStrobe;
    dataAcc = dataWr || dataRd;
    rdStat1 = dataRd && st.index == `HWM_IDX_STAT1;
    rdStat2 = dataRd && st.index == `HWM_IDX_STAT2;
    wrCfg = dataWr && st.index == `HWM_IDX_CFG;
    softInit = wrCfg && wrData[`HWM_CFG_INIT];
    gdis = st.cfg[`HWM_CFG_GDIS];
    running = st.cfg[`HWM_CFG_START] && !gdis;
    set1 = 8'h00;
    set2 = 8'h00;
    if (running) begin
      set1[4:0] = limitAlarm[4:0];
      set1[7:6] = tachAlarm[1:0];
      set2[2:0] = limitAlarm[7:5];
      set2[3] = tachAlarm[2];
    end
    if (!gdis) begin
      set1[`HWM_STAT1_BOARDTEMP] = !boardTempAlert_n;
      set2[`HWM_STAT2_CASEOPEN] = caseOpenIn && !st.caseOpenPrev;
      set2[`HWM_STAT2_POSTFULL] = postBufferFull;
      set2[`HWM_STAT2_CHAINED] = !chainedIrqIn_n && st.chainedPrev;
    end
    smiAny = maskedAny(st.stat1, st.smiMask1) ||
             maskedAny(st.stat2 & `HWM_STAT2_USED, st.smiMask2);
    hostAny = maskedAny(st.stat1, st.hostMask1);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.caseOpenPrev = caseOpenIn;
    next_st.chainedPrev = chainedIrqIn_n;
    next_st.pulseGo = 1'b0;
    next_st.pulseStop = 1'b0;
    // index port and busy flag
    if (wrStrobe && !portSel) begin
      next_st.index = wrData[6:0];
      next_st.busy = 1'b1;
    end else if (dataAcc) begin
      next_st.busy = 1'b0;
      if (autoAdvance(st.index)) begin
        next_st.index = st.index + 7'h1;
      end
    end
    // read data
    if (rdStrobe && !portSel) begin
      next_st.rdData = {st.busy, st.index};
    end else if (dataRd) begin
      case (st.index)
        `HWM_IDX_CFG: next_st.rdData = st.cfg;
        `HWM_IDX_STAT1: next_st.rdData = st.stat1;
        `HWM_IDX_STAT2: next_st.rdData = st.stat2;
        `HWM_IDX_SMIMASK1: next_st.rdData = st.smiMask1;
        `HWM_IDX_SMIMASK2: next_st.rdData = st.smiMask2;
        `HWM_IDX_HOSTMASK1: next_st.rdData = st.hostMask1;
        default: next_st.rdData = 8'h00;
      endcase
    end
    // sticky status, set wins over read clear
    next_st.stat1 = (st.stat1 & ~{8{rdStat1}}) | set1;
    next_st.stat2 = ((st.stat2 & ~{8{rdStat2}}) | set2) & `HWM_STAT2_USED;
    // register writes; status is read-only
    if (dataWr) begin
      case (st.index)
        `HWM_IDX_CFG: begin
          next_st.cfg = wrData;
          next_st.cfg[`HWM_CFG_INIT] = 1'b0;
          if (st.cfg[`HWM_CFG_RSTPULSE]) begin
            next_st.cfg[`HWM_CFG_RSTPULSE] = 1'b1;
          end else if (wrData[`HWM_CFG_RSTPULSE] && st.smiMask2[`HWM_MASK2_RSTPERM]) begin
            next_st.pulseGo = 1'b1;
          end else begin
            next_st.cfg[`HWM_CFG_RSTPULSE] = 1'b0;
          end
        end
        `HWM_IDX_SMIMASK1: next_st.smiMask1 = wrData;
        `HWM_IDX_SMIMASK2: next_st.smiMask2 = wrData;
        `HWM_IDX_HOSTMASK1: next_st.hostMask1 = wrData;
        default: begin
        end
      endcase
    end
    if (pulseDone) begin
      next_st.cfg[`HWM_CFG_RSTPULSE] = 1'b0;
    end
    if (softInit) begin
      next_st.cfg = ST_RST.cfg;
      next_st.stat1 = ST_RST.stat1;
      next_st.stat2 = ST_RST.stat2;
      next_st.smiMask1 = ST_RST.smiMask1;
      next_st.smiMask2 = ST_RST.smiMask2;
      next_st.hostMask1 = ST_RST.hostMask1;
      next_st.pulseGo = 1'b0;
      next_st.pulseStop = 1'b1;
    end
    // outputs; start bit is left out of the interrupt outputs on purpose and gates only monitorRun and limit/tach alarm capture
    next_st.smiOut_n = !(smiAny && st.cfg[`HWM_CFG_SMIEN] && !gdis);
    next_st.nmiOut_n = !(hostAny && st.cfg[`HWM_CFG_HOSTEN] && !gdis && st.cfg[`HWM_CFG_NMISEL]);
    next_st.irqOut_n = !(hostAny && st.cfg[`HWM_CFG_HOSTEN] && !gdis && !st.cfg[`HWM_CFG_NMISEL]);
    next_st.bypass_n = !st.cfg[`HWM_CFG_BYPASS];
    next_st.monitorRun = running;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // reset pulse timer
  // ****************************************
  hwm_pulse_timer #(
    .PULSE_CYC(PULSE_CYC)
  ) i_hwm_pulse_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(st.pulseGo),
    .abort(st.pulseStop),
    .pulse_n(pulseLow_n),
    .done(pulseDone)
  );

  assign rdData = st.rdData;
  assign systemMgmtIrqOut_n = st.smiOut_n;
  assign nmiOut_n = st.nmiOut_n;
  assign irqOut_n = st.irqOut_n;
  assign resetOut_n = pulseLow_n;
  assign powerBypassOut_n = st.bypass_n;
  assign monitorEnable = st.monitorRun;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence cfgWrite;
    dataWr && st.index == `HWM_IDX_CFG;
  endsequence

  sequence stat1Access;
    dataAcc && !wrStrobe ? 1'b1 : dataAcc;
  endsequence

  idx_advance_a: assert property (
    (stat1Access and (st.index == `HWM_IDX_STAT1) and !(wrStrobe && !portSel)) |=> st.index == `HWM_IDX_STAT2
  ) else $error("index did not advance past first status");

  cfg_read_a: assert property (
    (dataRd && st.index == `HWM_IDX_CFG) ##1 1'b1 |-> rdData == $past(st.cfg)
  ) else $error("data port returned wrong configuration");

  run_follow_a: assert property (
    ##1 monitorEnable == $past(st.cfg[`HWM_CFG_START] && !st.cfg[`HWM_CFG_GDIS])
  ) else $error("monitor enable does not follow start and disable");

  smi_gate_a: assert property (
    !st.cfg[`HWM_CFG_SMIEN] [*2] |-> systemMgmtIrqOut_n
  ) else $error("management interrupt driven while disabled");

  host_select_a: assert property (
    ##1 !nmiOut_n |-> $past(st.cfg[`HWM_CFG_NMISEL] && st.cfg[`HWM_CFG_HOSTEN]) && irqOut_n
  ) else $error("host interrupt routed to wrong output");

  gdis_hold_a: assert property (
    (gdis && !rdStat1 && !rdStat2 && !softInit) |=> $stable(st.stat1) && $stable(st.stat2) && systemMgmtIrqOut_n
  ) else $error("global disable did not freeze status or outputs");

  stop_keeps_a: assert property (
    (cfgWrite and !wrData[`HWM_CFG_START] and !systemMgmtIrqOut_n and smiAny and st.cfg[`HWM_CFG_SMIEN] and !gdis
     and !rdStat1 and !rdStat2) |=> !systemMgmtIrqOut_n
  ) else $error("clearing start released the interrupt");

  pulse_perm_a: assert property (
    (cfgWrite and !st.smiMask2[`HWM_MASK2_RSTPERM] and !st.cfg[`HWM_CFG_RSTPULSE]) |=> !st.cfg[`HWM_CFG_RSTPULSE]
  ) else $error("reset pulse bit set without permission");

  pulse_start_a: assert property (
    (cfgWrite and wrData[`HWM_CFG_RSTPULSE] and st.smiMask2[`HWM_MASK2_RSTPERM] and !wrData[`HWM_CFG_INIT]
     and !st.cfg[`HWM_CFG_RSTPULSE]) |=> ##1 !resetOut_n ##1 !resetOut_n
  ) else $error("reset pulse did not start");

  bypass_pin_a: assert property (
    ##1 powerBypassOut_n == !$past(st.cfg[`HWM_CFG_BYPASS])
  ) else $error("bypass pin does not follow configuration");

  soft_init_a: assert property (
    softInit |=> st.cfg == `HWM_RST_CFG && st.smiMask2 == 8'h00 && st.stat1 == 8'h00
  ) else $error("soft restore left a register changed");

  sticky_flag_a: assert property (
    (!rdStat1 && !softInit) |=> ($past(st.stat1) & ~st.stat1) == 8'h00
  ) else $error("status flag cleared without a read");

endmodule // hwm_irq_ctrl

// ---- dv/hwm_host_model.sv ----
// host side of the index/data port pair of the monitor control block
// assumes one access per strobe, taken at the rising edge of clk_sys
`timescale 1ns/100ps
module hwm_host_model (
  input wire logic clk_sys,
  output logic portSel,
  output logic wrStrobe,
  output logic rdStrobe,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  // ****************************************
  // port accesses, driven at the falling edge
  // ****************************************
  initial begin
    portSel = 1'b0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    wrData = 8'h00;
  end

  task automatic acc(input logic sel, input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    portSel = sel;
    wrStrobe = wr;
    rdStrobe = !wr;
    wrData = d;
    @(negedge clk_sys);
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    wrData = ~d;
    q = rdData;
  endtask

  task automatic wreg(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, 1'b1, {1'b0, idx}, q);
    acc(1'b1, 1'b1, d, q);
  endtask

  task automatic rreg(input logic [6:0] idx, output logic [7:0] q);
    acc(1'b0, 1'b1, {1'b0, idx}, q);
    acc(1'b1, 1'b0, 8'h00, q);
  endtask
endmodule // hwm_host_model

// ---- dv/tb_hwm_irq_ctrl.sv ----
// self-checking bench for the monitor control block
// assumes the host model drives the port pair; events driven here
`timescale 1ns/100ps
module tb_hwm_irq_ctrl;
  logic clk_sys;
  logic rst_n;
  logic portSel;
  logic wrStrobe;
  logic rdStrobe;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic [7:0] limitAlarm;
  logic [2:0] tachAlarm;
  logic boardTempAlert_n;
  logic caseOpenIn;
  logic postBufferFull;
  logic chainedIrqIn_n;
  logic systemMgmtIrqOut_n;
  logic nmiOut_n;
  logic irqOut_n;
  logic resetOut_n;
  logic powerBypassOut_n;
  logic monitorEnable;
  int err_total = 0;
  int cmp_count = 0;
  localparam logic [15:0] MAP [15] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0100,
    16'h0200, 16'h0400, 16'h0040, 16'h0080, 16'h0800, 16'h0020, 16'h1000, 16'h2000, 16'h4000};
  // cfg, smi mask 1, smi mask 2, host mask 1, source, {smi, nmi, irq}
  localparam logic [47:0] ROW [9] = '{48'h070000000002, 48'h270000000001, 48'h070100000006,
    48'h070000010003, 48'h050000000006, 48'h030000000003, 48'h070001000507, 48'h070000000503,
    48'h0f0000000007};

  // ****************************************
  // design, host and clock
  // ****************************************
  hwm_irq_ctrl #(.PULSE_CYC(8)) i_hwm_irq_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .portSel(portSel),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData), .limitAlarm(limitAlarm),
    .tachAlarm(tachAlarm), .boardTempAlert_n(boardTempAlert_n), .caseOpenIn(caseOpenIn),
    .postBufferFull(postBufferFull), .chainedIrqIn_n(chainedIrqIn_n), .systemMgmtIrqOut_n(systemMgmtIrqOut_n),
    .nmiOut_n(nmiOut_n), .irqOut_n(irqOut_n), .resetOut_n(resetOut_n), .powerBypassOut_n(powerBypassOut_n),
    .monitorEnable(monitorEnable));
  hwm_host_model i_hwm_host_model (.clk_sys(clk_sys), .portSel(portSel), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] outs();
    return {5'h00, systemMgmtIrqOut_n, nmiOut_n, irqOut_n};
  endfunction

  task automatic fire(input int s);
    @(negedge clk_sys);
    if (s < 8) limitAlarm[s] = 1'b1;
    else if (s < 11) tachAlarm[s - 8] = 1'b1;
    else if (s == 11) boardTempAlert_n = 1'b0;
    else if (s == 12) caseOpenIn = 1'b1;
    else if (s == 13) postBufferFull = 1'b1;
    else chainedIrqIn_n = 1'b0;
    @(negedge clk_sys);
    limitAlarm = 8'h00;
    tachAlarm = 3'h0;
    boardTempAlert_n = 1'b1;
    caseOpenIn = 1'b0;
    postBufferFull = 1'b0;
    chainedIrqIn_n = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic rstat(output logic [15:0] s);
    logic [7:0] a;
    logic [7:0] b;
    i_hwm_host_model.rreg(7'h41, a);
    i_hwm_host_model.acc(1'b1, 1'b0, 8'h00, b);
    s = {b, a};
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] q;
    chk(rdData, 8'h00);
    chk({2'b00, systemMgmtIrqOut_n, nmiOut_n, irqOut_n, resetOut_n, powerBypassOut_n, monitorEnable}, 8'h3e);
    for (int i = 0; i < 6; i++) begin
      i_hwm_host_model.rreg(7'(64 + i), q);
      chk(q, (i == 0) ? 8'h08 : 8'h00);
    end
    $display("reset values done");
  endtask

  task automatic t_ro;
    logic [7:0] q;
    logic [15:0] s;
    i_hwm_host_model.wreg(7'h41, 8'hff);
    rstat(s);
    chk(s[7:0], 8'h00);
    i_hwm_host_model.rreg(7'h4a, q);
    chk(q, 8'h00);
    i_hwm_host_model.acc(1'b0, 1'b1, 8'h43, q);
    i_hwm_host_model.acc(1'b0, 1'b0, 8'h00, q);
    chk(q, 8'hc3);
    i_hwm_host_model.acc(1'b1, 1'b0, 8'h00, q);
    i_hwm_host_model.acc(1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h44);
    $display("port access done");
  endtask

  task automatic t_map;
    logic [15:0] v;
    i_hwm_host_model.wreg(7'h40, 8'h01);
    for (int s = 0; s < 15; s++) begin
      fire(s);
      rstat(v);
      chk(v[7:0], MAP[s][7:0]);
      chk(v[15:8], MAP[s][15:8]);
    end
    $display("event map done");
  endtask

  task automatic t_mask;
    logic [15:0] s;
    for (int i = 0; i < 9; i++) begin
      i_hwm_host_model.wreg(7'h43, ROW[i][39:32]);
      i_hwm_host_model.wreg(7'h44, ROW[i][31:24]);
      i_hwm_host_model.wreg(7'h45, ROW[i][23:16]);
      i_hwm_host_model.wreg(7'h40, ROW[i][47:40]);
      fire(int'(ROW[i][15:8]));
      chk(outs(), ROW[i][7:0]);
      chk({7'h00, monitorEnable}, {7'h00, ROW[i][40] & !ROW[i][43]});
      rstat(s);
      if (ROW[i][43]) chk(s[7:0], 8'h00);
      repeat (2) @(negedge clk_sys);
      chk(outs(), 8'h07);
    end
    $display("masking done");
  endtask

  task automatic t_hold;
    logic [15:0] s;
    i_hwm_host_model.wreg(7'h40, 8'h07);
    fire(0);
    i_hwm_host_model.wreg(7'h40, 8'h06);
    repeat (2) @(negedge clk_sys);
    chk(outs(), 8'h02);
    rstat(s);
    $display("start clear done");
  endtask

  task automatic t_pulse;
    logic [7:0] q;
    int n;
    int i;
    n = 0;
    i_hwm_host_model.wreg(7'h40, 8'h18);
    repeat (4) @(negedge clk_sys);
    chk({7'h00, resetOut_n}, 8'h01);
    i_hwm_host_model.rreg(7'h40, q);
    chk(q, 8'h08);
    i_hwm_host_model.wreg(7'h44, 8'h80);
    i_hwm_host_model.wreg(7'h40, 8'h18);
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (resetOut_n === 1'b0) n++;
      else if (n > 0) break;
    end
    if (i == 60) begin
      err_total++;
      finish_test;
    end
    chk(8'(n), 8'd8);
    i_hwm_host_model.rreg(7'h40, q);
    chk(q, 8'h08);
    $display("reset pulse done");
  endtask

  task automatic t_init;
    logic [7:0] q;
    i_hwm_host_model.wreg(7'h40, 8'h48);
    repeat (2) @(negedge clk_sys);
    chk({7'h00, powerBypassOut_n}, 8'h00);
    i_hwm_host_model.wreg(7'h43, 8'hff);
    i_hwm_host_model.wreg(7'h40, 8'h80);
    repeat (2) @(negedge clk_sys);
    i_hwm_host_model.rreg(7'h40, q);
    chk(q, 8'h08);
    i_hwm_host_model.rreg(7'h43, q);
    chk(q, 8'h00);
    chk({7'h00, powerBypassOut_n}, 8'h01);
    $display("restore done");
  endtask

  initial begin
    rst_n = 1'b0;
    limitAlarm = 8'h00;
    tachAlarm = 3'h0;
    boardTempAlert_n = 1'b1;
    caseOpenIn = 1'b0;
    postBufferFull = 1'b0;
    chainedIrqIn_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset;
    t_ro;
    t_map;
    t_mask;
    t_hold;
    t_pulse;
    t_init;
    finish_test;
  end
endmodule // tb_hwm_irq_ctrl
